// File: src/gds_pkg.sv
/*
  gds_pkg: constants, carriers and state codes of the ground directional
  supervision block.
  Assumes one 40 MHz clock, rectangular phasors from the front end with
  currents in 0.1 mA counts, and 16-bit software registers.
*/
package gds_pkg;

  // ==========================================================
  // clock and coordination timer
  localparam int CLK_PERIOD_NS = 25;
  localparam int COORD_UNIT_NS = 1000000;      // coordination time counts in ms
  localparam int TICK_CYCLES   = (COORD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // magnitude thresholds, squared counts for the energy compare
  localparam int          I_LSB_UA      = 100;
  localparam int          OP_MIN_GND_UA = 60000;
  localparam int          OP_MIN_SEN_UA = 2700;
  localparam int          IG_MIN_UA     = 60000;
  localparam logic [31:0] OP_MIN_GND_SQ = 32'((OP_MIN_GND_UA / I_LSB_UA) * (OP_MIN_GND_UA / I_LSB_UA));
  localparam logic [31:0] OP_MIN_SEN_SQ = 32'((OP_MIN_SEN_UA / I_LSB_UA) * (OP_MIN_SEN_UA / I_LSB_UA));
  localparam logic [31:0] IG_MIN_SQ     = 32'((IG_MIN_UA / I_LSB_UA) * (IG_MIN_UA / I_LSB_UA));

  // ==========================================================
  // trig scale: Q2.14, angles in whole degrees
  localparam int                 TRIG_FRAC = 14;
  localparam logic signed [15:0] TRIG_ONE  = 16'sh4000;
  localparam logic [6:0]         ANG_MAX   = 7'h5A;

  // ==========================================================
  // register map
  localparam int         ADDR_W    = 3;
  localparam int         DATA_W    = 16;
  localparam logic [2:0] REG_CTRL  = 3'h0;
  localparam logic [2:0] REG_VMIN  = 3'h1;
  localparam logic [2:0] REG_ANGLE = 3'h2;
  localparam logic [2:0] REG_KCOMP = 3'h3;
  localparam logic [2:0] REG_COORD = 3'h4;
  localparam logic [2:0] REG_STAT  = 3'h5;
  // control fields
  localparam int CTRL_MODE = 0;                 // two bits
  localparam int CTRL_SENS = 2;                 // sensitive-ground unit
  localparam int CTRL_COMP = 3;                 // compensated polarization
  localparam int CTRL_LPB  = 4;                 // lack-of-polarization blocking
  localparam int CTRL_LVPB = 5;                 // lack-of-voltage-polarization blocking
  localparam int CTRL_INH  = 6;                 // inhibit directional element
  localparam int CTRL_REV  = 7;                 // reverse direction setting
  // status fields
  localparam int ST_DEC  = 0;                   // four bits
  localparam int ST_TRIP = 4;                   // six bits
  localparam int ST_TOC  = 10;
  localparam int ST_REVL = 11;
  // reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] VMIN_RST  = 16'h0000;
  localparam logic [6:0]  ANGLE_RST = 7'h00;
  localparam logic [7:0]  KCOMP_RST = 8'h00;
  localparam logic [15:0] COORD_RST = 16'h0000;

  // ==========================================================
  // types
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } gds_phasor_s;

  typedef struct packed {
    gds_phasor_s op;                            // zero-sequence operate current
    gds_phasor_s v0;                            // zero-sequence voltage
    gds_phasor_s ig;                            // ground-path current
  } gds_meas_s;

  typedef struct packed {
    logic fwdInst;
    logic fwdToc;
    logic revInst;
    logic revToc;
    logic ocInst;                               // selected by direction setting
    logic ocToc;
  } gds_trip_s;

  typedef enum logic [1:0] {
    MODE_VOLT = 2'h0,
    MODE_CURR = 2'h1,
    MODE_BOTH = 2'h2
  } gds_mode_e;

  typedef enum logic [3:0] {
    DEC_INH = 4'h1,
    DEC_FWD = 4'h2,
    DEC_REV = 4'h4,
    DEC_BLK = 4'h8
  } gds_dec_e;

endpackage : gds_pkg

// File: src/gds_trig_rom.sv
/*
  gds_trig_rom: cosine and sine of the characteristic angle in Q2.14.
  Assumes the angle is a slow software setting; results are registered,
  so they trail an angle write by one clock.
*/
module gds_trig_rom (
  input  wire logic               clock,     // 40 MHz
  input  wire logic               rst,       // synchronous, high
  input  wire logic [6:0]         angle,     // degrees
  output logic signed [15:0]      cosA,      // registered cosine
  output logic signed [15:0]      sinA       // registered sine
);

  // ==========================================================
  // rational sine approximation, exact at 0, 30, 90 degrees
  function automatic logic signed [15:0] sinDeg(input logic [6:0] deg);
    int x;
    int p;
    x = int'(deg);
    p = x * (180 - x);
    sinDeg = 16'((4 * p * 16384) / (40500 - p));
  endfunction : sinDeg

  typedef struct packed {
    logic signed [15:0] cosV;
    logic signed [15:0] sinV;
  } gds_trig_s;

  logic [6:0] angClip;
  gds_trig_s  trig_q;
  gds_trig_s  trig_d;

  // settings above 90 degrees are held at 90
  assign angClip = (angle > gds_pkg::ANG_MAX) ? gds_pkg::ANG_MAX : angle;

  // table values for the clipped angle
  always_comb
  begin
    trig_d.cosV = sinDeg(7'(gds_pkg::ANG_MAX - angClip));
    trig_d.sinV = sinDeg(angClip);
  end

  // registered table output, so the divider never sits in the multiplier path
  always_ff @(posedge clock)
  begin
    if (rst)
      trig_q <= '{cosV: gds_pkg::TRIG_ONE, sinV: 16'sh0000};
    else
      trig_q <= trig_d;
  end

  assign cosA = trig_q.cosV;
  assign sinA = trig_q.sinV;

endmodule : gds_trig_rom

// File: src/gds_supervisor.sv
/*
  gds_supervisor: ground and sensitive-ground directional supervision.
  Holds the settings registers, decides direction on each phasor set and
  drives the trip enables of the overcurrent elements.
  Assumes phasors and measValid come from logic on the same clock, the
  reversal input comes from a pin, and the register master never waits.
*/
module gds_supervisor #(
  parameter int TICK_CYCLES = gds_pkg::TICK_CYCLES  // clocks per ms
) (
  input  wire logic                     clock,     // 40 MHz
  input  wire logic                     rst,       // synchronous, high
  input  wire logic [2:0]               regAddr,   // register index
  input  wire logic [15:0]              regWdata,  // write data
  input  wire logic                     regWr,     // write strobe
  input  wire logic                     regRd,     // read strobe
  output logic [15:0]                   regRdata,  // read data, cycle after strobe
  input  wire logic                     measValid, // new phasor set
  input  wire gds_pkg::gds_meas_s       meas,      // phasor set
  input  wire logic                     dirRevPin, // direction reversal, asynchronous
  output gds_pkg::gds_trip_s            trip       // trip enables
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]         ctrl;
    logic [15:0]        vmin;
    logic [6:0]         angle;
    logic [7:0]         kcomp;
    logic [15:0]        coord;
    logic [2:0]         revSync;
    logic               revLvl;
    gds_pkg::gds_dec_e  dec;
    logic [15:0]        tick;
    logic [15:0]        msCnt;
    logic               tocOk;
    gds_pkg::gds_trip_s trip;
    logic [15:0]        rdata;
  } gds_state_s;

  gds_state_s         q;
  gds_state_s         n;
  logic signed [15:0] cosA;
  logic signed [15:0] sinA;

  // ==========================================================
  // arithmetic helpers
  function automatic logic signed [63:0] magSq(input logic signed [31:0] re, input logic signed [31:0] im);
    magSq = 64'(re) * 64'(re) + 64'(im) * 64'(im);
  endfunction : magSq

  // real part of op * conj(pol) * (c + js): sign gives the half plane
  function automatic logic signed [63:0] torque(input logic signed [31:0] ar, input logic signed [31:0] ai,
                                                input logic signed [31:0] pr, input logic signed [31:0] pi,
                                                input logic signed [15:0] c, input logic signed [15:0] s);
    logic signed [63:0] dot;
    logic signed [63:0] crs;
    dot    = 64'(ar) * 64'(pr) + 64'(ai) * 64'(pi);
    crs    = 64'(ai) * 64'(pr) - 64'(ar) * 64'(pi);
    torque = dot * 64'(c) - crs * 64'(s);
  endfunction : torque
  function automatic gds_pkg::gds_dec_e pick(input logic fwd);
    pick = fwd ? gds_pkg::DEC_FWD : gds_pkg::DEC_REV;
  endfunction : pick

  // ==========================================================
  // characteristic angle table
  gds_trig_rom i_gds_trig_rom (
    .clock (clock),
    .rst   (rst),
    .angle (q.angle),
    .cosA  (cosA),
    .sinA  (sinA)
  );

  // ==========================================================
  // polarizing phasors and magnitude checks
  logic signed [63:0] compRe;
  logic signed [63:0] compIm;
  logic signed [31:0] polVRe;
  logic signed [31:0] polVIm;
  logic signed [31:0] polIRe;
  logic signed [31:0] polIIm;
  logic signed [63:0] tVolt;
  logic signed [63:0] tCur;
  logic               opOk;
  logic               igOk;
  logic               vOk;
  logic               dirVolt;
  logic               dirCur;
  gds_pkg::gds_mode_e mode;
  gds_pkg::gds_dec_e  newDec;

  // compensation term: operate current times factor at the characteristic angle
  // compensated polarizing term
  always_comb
  begin
    compRe = ((64'(meas.op.re) * 64'(cosA) - 64'(meas.op.im) * 64'(sinA)) * 64'($signed({1'b0, q.kcomp})))
             >>> gds_pkg::TRIG_FRAC;
    compIm = ((64'(meas.op.re) * 64'(sinA) + 64'(meas.op.im) * 64'(cosA)) * 64'($signed({1'b0, q.kcomp})))
             >>> gds_pkg::TRIG_FRAC;
    if (!q.ctrl[gds_pkg::CTRL_COMP])
    begin
      compRe = '0;
      compIm = '0;
    end
  end

  // negated zero-sequence voltage, plus compensation when enabled
  // negated voltage as polarizing
  assign polVRe = 32'(compRe) - 32'(meas.v0.re);
  assign polVIm = 32'(compIm) - 32'(meas.v0.im);

  // ground current turned half a turn
  // ground current rotated
  assign polIRe = -32'(meas.ig.re);
  assign polIIm = -32'(meas.ig.im);

  // operate threshold depends on unit type; voltage threshold is settable
  // minimum magnitudes
  assign opOk = magSq(32'(meas.op.re), 32'(meas.op.im)) >
                64'(q.ctrl[gds_pkg::CTRL_SENS] ? gds_pkg::OP_MIN_SEN_SQ : gds_pkg::OP_MIN_GND_SQ);
  assign vOk  = magSq(polVRe, polVIm) > 64'(q.vmin) * 64'(q.vmin);
  assign igOk = magSq(polIRe, polIIm) > 64'(gds_pkg::IG_MIN_SQ);

  // torque signs; zero torque sits on the boundary and counts as forward
  // angle against zero-sequence voltage
  assign tVolt = torque(32'(meas.op.re), 32'(meas.op.im), polVRe, polVIm, cosA, sinA);
  assign tCur  = torque(32'(meas.op.re), 32'(meas.op.im), polIRe, polIIm, gds_pkg::TRIG_ONE, 16'sh0000);

  // reversal input inverts whichever direction was found
  // voltage direction with reversal
  assign dirVolt = (tVolt >= 64'sh0) ^ q.revLvl;
  assign dirCur  = (tCur >= 64'sh0) ^ q.revLvl;

  // sensitive units have only voltage polarization
  // no current mode on sensitive units
  assign mode = (q.ctrl[gds_pkg::CTRL_SENS] || q.ctrl[1:0] == 2'h3) ? gds_pkg::MODE_VOLT
                                                                      : gds_pkg::gds_mode_e'(q.ctrl[1:0]);

  // ==========================================================
  // direction decision for the present phasor set
  always_comb
  begin
    newDec = gds_pkg::DEC_INH;
    if (!q.ctrl[gds_pkg::CTRL_INH])
    begin
      case (mode)
        gds_pkg::MODE_CURR:
        begin
          if (!igOk)
            newDec = q.ctrl[gds_pkg::CTRL_LPB] ? gds_pkg::DEC_BLK : gds_pkg::DEC_INH;
          else
            newDec = pick(dirCur);
        end
        gds_pkg::MODE_BOTH:
        begin
          if (!opOk)
            newDec = q.ctrl[gds_pkg::CTRL_LVPB] ? gds_pkg::DEC_BLK : gds_pkg::DEC_INH;
          else if (igOk)
            newDec = pick(dirCur);
          else if (!vOk)
            newDec = q.ctrl[gds_pkg::CTRL_LVPB] ? gds_pkg::DEC_BLK : gds_pkg::DEC_INH;
          else
            newDec = pick(dirVolt);
        end
        default:
        begin
          if (!opOk || !vOk)
            newDec = q.ctrl[gds_pkg::CTRL_LPB] ? gds_pkg::DEC_BLK : gds_pkg::DEC_INH;
          else
            newDec = pick(dirVolt);
        end
      endcase
    end
  end

  // ==========================================================
  // next state: registers, pin sync, timer, trip enables
  always_comb
  begin
    n       = q;
    n.rdata = 16'h0000;
    // three-stage sync; a change counts once the last two stages agree
    n.revSync = {q.revSync[1:0], dirRevPin};
    if (q.revSync[1] == q.revSync[2])
      n.revLvl = q.revSync[2];

    // register writes
    if (regWr)
    begin
      if (regAddr == gds_pkg::REG_CTRL)
        n.ctrl = regWdata[7:0];
      else if (regAddr == gds_pkg::REG_VMIN)
        n.vmin = regWdata;
      else if (regAddr == gds_pkg::REG_ANGLE)
        n.angle = regWdata[6:0];
      else if (regAddr == gds_pkg::REG_KCOMP)
        n.kcomp = regWdata[7:0];
      else if (regAddr == gds_pkg::REG_COORD)
        n.coord = regWdata;
    end

    // register reads; unmapped indexes answer zero
    if (regRd)
    begin
      if (regAddr == gds_pkg::REG_CTRL)
        n.rdata = {8'h00, q.ctrl};
      else if (regAddr == gds_pkg::REG_VMIN)
        n.rdata = q.vmin;
      else if (regAddr == gds_pkg::REG_ANGLE)
        n.rdata = {9'h000, q.angle};
      else if (regAddr == gds_pkg::REG_KCOMP)
        n.rdata = {8'h00, q.kcomp};
      else if (regAddr == gds_pkg::REG_COORD)
        n.rdata = q.coord;
      else if (regAddr == gds_pkg::REG_STAT)
      begin
        n.rdata[gds_pkg::ST_DEC +: 4]  = q.dec;
        n.rdata[gds_pkg::ST_TRIP +: 6] = q.trip;
        n.rdata[gds_pkg::ST_TOC]       = q.tocOk;
        n.rdata[gds_pkg::ST_REVL]      = q.revLvl;
      end
    end

    // decision is taken only on a new phasor set, held in between
    // re-decide per phasor set
    if (measValid)
      n.dec = newDec;

    // coordination timer: ms prescaler then ms count; restarts on change
    // restart on direction change
    if (n.dec != q.dec)
    begin
      n.tick  = 16'h0000;
      n.msCnt = 16'h0000;
      n.tocOk = 1'b0;
    end
    else if (!q.tocOk)
    begin
      if (q.msCnt >= q.coord)
        n.tocOk = 1'b1;
      else if (q.tick == 16'(TICK_CYCLES - 1))
      begin
        n.tick  = 16'h0000;
        n.msCnt = q.msCnt + 16'h0001;
      end
      else
        n.tick = q.tick + 16'h0001;
    end

    // trip enables from the new decision so outputs track it directly
    n.trip = '0;
    case (n.dec)
      gds_pkg::DEC_FWD:
      begin
        n.trip.fwdInst = 1'b1;
        n.trip.fwdToc  = n.tocOk;
      end
      gds_pkg::DEC_REV:
      begin
        n.trip.revInst = 1'b1;
        n.trip.revToc  = n.tocOk;
      end
      gds_pkg::DEC_INH:
      begin
        n.trip.fwdInst = 1'b1;
        n.trip.revInst = 1'b1;
        n.trip.fwdToc  = n.tocOk;
        n.trip.revToc  = n.tocOk;
      end
      default: n.trip = '0;
    endcase
    // the supervised element follows its direction setting
    // direction setting selects half plane
    n.trip.ocInst = n.ctrl[gds_pkg::CTRL_REV] ? n.trip.revInst : n.trip.fwdInst;
    n.trip.ocToc  = n.ctrl[gds_pkg::CTRL_REV] ? n.trip.revToc : n.trip.fwdToc;
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      q.ctrl    <= gds_pkg::CTRL_RST;
      q.vmin    <= gds_pkg::VMIN_RST;
      q.angle   <= gds_pkg::ANGLE_RST;
      q.kcomp   <= gds_pkg::KCOMP_RST;
      q.coord   <= gds_pkg::COORD_RST;
      q.revSync <= 3'h0;
      q.revLvl  <= 1'b0;
      q.dec     <= gds_pkg::DEC_BLK;  // nothing trips before the first phasor set
      q.tick    <= 16'h0000;
      q.msCnt   <= 16'h0000;
      q.tocOk   <= 1'b0;
      q.trip    <= '0;
      q.rdata   <= 16'h0000;
    end
    else
      q <= n;
  end
  assign regRdata = q.rdata;
  assign trip     = q.trip;

  // ==========================================================
  // checks
  property p_blk;
    @(posedge clock) disable iff (rst)
    q.dec == gds_pkg::DEC_BLK |-> trip == '0;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked decision left a trip enabled");
  property p_fwd;
    @(posedge clock) disable iff (rst)
    q.dec == gds_pkg::DEC_FWD |-> trip.fwdInst && !trip.revInst && !trip.revToc && trip.fwdToc == q.tocOk;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward enables wrong");
  property p_rev;
    @(posedge clock) disable iff (rst)
    q.dec == gds_pkg::DEC_REV |-> trip.revInst && !trip.fwdInst && !trip.fwdToc && trip.revToc == q.tocOk;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse enables wrong");
  property p_inh;
    @(posedge clock) disable iff (rst)
    q.dec == gds_pkg::DEC_INH |-> trip.fwdInst && trip.revInst && (trip.fwdToc == q.tocOk);
  endproperty
  a_inh: assert property (p_inh) else $error("inhibited element not enabling both ways");
  property p_restart;
    @(posedge clock) disable iff (rst)
    q.dec != $past(q.dec) |-> !q.tocOk && q.tick == 16'h0000 && q.msCnt == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted on change");
  property p_tocWait;
    @(posedge clock) disable iff (rst)
    $rose(q.tocOk) && q.coord != 16'h0000 |-> $past(q.msCnt) >= q.coord && $past(q.tick) == 16'h0000;
  endproperty
  a_tocWait: assert property (p_tocWait) else $error("time trip released early");
  property p_opMin;
    @(posedge clock) disable iff (rst)
    measValid && mode == gds_pkg::MODE_VOLT && !q.ctrl[gds_pkg::CTRL_INH] && !opOk && !regWr
      |=> q.dec == ($past(q.ctrl[gds_pkg::CTRL_LPB]) ? gds_pkg::DEC_BLK : gds_pkg::DEC_INH);
  endproperty
  a_opMin: assert property (p_opMin) else $error("weak operate current decided a direction");
  property p_curRev;
    @(posedge clock) disable iff (rst)
    measValid && mode == gds_pkg::MODE_BOTH && !q.ctrl[gds_pkg::CTRL_INH] && opOk && igOk
      |=> q.dec == (($past(tCur) >= 64'sh0) ^ $past(q.revLvl) ? gds_pkg::DEC_FWD : gds_pkg::DEC_REV);
  endproperty
  a_curRev: assert property (p_curRev) else $error("combined current decision wrong");
  property p_ocSel;
    @(posedge clock) disable iff (rst)
    !q.ctrl[gds_pkg::CTRL_REV] |-> trip.ocInst == trip.fwdInst && trip.ocToc == trip.fwdToc;
  endproperty
  a_ocSel: assert property (p_ocSel) else $error("forward setting not followed");

endmodule : gds_supervisor

// File: dv/gds_front_model.sv
/*
  gds_front_model: phasor front end that feeds the supervisor one phasor
  set on request, chosen from a small table of fault cases.
  Assumes the bench raises sendReq for one cycle right after a clock edge.
*/
module gds_front_model (
  input  wire logic          clock,     // shared 40 MHz clock
  input  wire logic          sendReq,   // one-cycle request
  input  wire logic [2:0]    kind,      // fault case to send
  output logic               measValid, // one-cycle pulse
  output gds_pkg::gds_meas_s meas       // phasor set {op, v0, ig}
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // fault cases, counts of 0.1 mA and volts
  function automatic gds_pkg::gds_meas_s setFor(input logic [2:0] k);
    case (k)
      3'h0: return {16'h03E8, 16'h0000, 16'hFC18, 48'h0};          // voltage forward
      3'h1: return {16'hFC18, 16'h0000, 16'hFC18, 48'h0};          // voltage reverse
      3'h2: return {16'h000A, 16'h0000, 16'hFC18, 48'h0};          // operate too weak
      3'h3: return {16'h03E8, 16'h0000, 16'h03E8, 16'h0000, 16'hFC18, 16'h0000}; // current fwd, voltage rev
      3'h4: return {16'h03E8, 16'h0000, 16'hFC18, 16'h0000, 16'h0064, 16'h0000}; // ground current weak
      3'h6: return {16'h0000, 16'h03E8, 16'hFC18, 48'h0};          // operate 90 degrees ahead
      default: return {16'h001E, 16'h0000, 16'hFC18, 48'h0};       // only sensitive level
    endcase
  endfunction : setFor

  // ==========================================================
  // outside a set the lines toggle, so a stale sample never passes
  initial meas = '0;
  always @(posedge clock)
  begin
    measValid <= sendReq;
    meas      <= sendReq ? setFor(kind) : ~meas;
  end
endmodule : gds_front_model

// File: dv/gds_supervisor_bench.sv
/*
  gds_supervisor_bench: register and fault-case tests of the supervisor.
  Assumes TICK_CYCLES of 4 and a coordination time of 2 ms, so the time
  trips follow the instantaneous ones after about ten cycles.
*/
module gds_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clock = 1'b0;
  logic               rst = 1'b1;
  logic [2:0]         regAddr = 3'h0;
  logic [15:0]        regWdata = 16'h0000;
  logic               regWr = 1'b0;
  logic               regRd = 1'b0;
  logic [15:0]        regRdata;
  logic               measValid;
  gds_pkg::gds_meas_s meas;
  logic               dirRevPin = 1'b0;
  gds_pkg::gds_trip_s trip;
  logic               sendReq = 1'b0;
  logic [2:0]         kind = 3'h0;
  int                 failures = 0;
  int                 totalChecks = 0;
  int                 cycleCount = 0;
  // {ctrl, pin, kind, trip after set, trip after timer}
  logic [31:0]        tbl [18] = '{
    {16'h0000, 1'h0, 3'h0, 6'h22, 6'h33}, {16'h0000, 1'h0, 3'h1, 6'h08, 6'h0C},
    {16'h0080, 1'h0, 3'h1, 6'h0A, 6'h0F}, {16'h0000, 1'h0, 3'h2, 6'h2A, 6'h3F},
    {16'h0004, 1'h0, 3'h5, 6'h22, 6'h33}, {16'h0000, 1'h0, 3'h5, 6'h2A, 6'h3F},
    {16'h0001, 1'h0, 3'h3, 6'h22, 6'h33}, {16'h0001, 1'h0, 3'h4, 6'h2A, 6'h3F},
    {16'h0011, 1'h0, 3'h4, 6'h00, 6'h00}, {16'h0002, 1'h0, 3'h3, 6'h22, 6'h33},
    {16'h0002, 1'h0, 3'h4, 6'h22, 6'h33}, {16'h0022, 1'h0, 3'h2, 6'h00, 6'h00},
    {16'h0005, 1'h0, 3'h3, 6'h08, 6'h0C}, {16'h0008, 1'h0, 3'h3, 6'h22, 6'h33},
    {16'h0040, 1'h0, 3'h1, 6'h2A, 6'h3F}, {16'h0000, 1'h1, 3'h0, 6'h08, 6'h0C},
    {16'h0003, 1'h0, 3'h3, 6'h08, 6'h0C}, {16'h0002, 1'h1, 3'h3, 6'h08, 6'h0C}};

  gds_supervisor #(.TICK_CYCLES(4)) i_gds_supervisor (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .measValid(measValid),
    .meas(meas), .dirRevPin(dirRevPin), .trip(trip));
  gds_front_model i_gds_front_model (.clock(clock), .sendReq(sendReq), .kind(kind),
    .measValid(measValid), .meas(meas));

  // ==========================================================
  // clock and hang guard
  initial forever #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 3000)
    begin
      failures++;
      complete_run();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clock);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rd

  // phasor set taken one cycle after the request, trips one cycle later
  task send(input logic [2:0] k);
    @(posedge clock);
    sendReq <= 1'b1;
    kind    <= k;
    @(posedge clock);
    sendReq <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : send

  // one fault case: park in blocked, then the case, then again after the timer
  task runCase(input logic [31:0] e);
    wr(gds_pkg::REG_CTRL, 16'h0010);
    dirRevPin <= e[15];
    send(3'h2);
    #1 chk({10'h0, trip}, 16'h0000);
    wr(gds_pkg::REG_CTRL, e[31:16]);
    send(e[14:12]);
    #1 chk({10'h0, trip}, {10'h0, e[11:6]});
    repeat (20) @(posedge clock);
    #1 chk({10'h0, trip}, {10'h0, e[5:0]});
  endtask : runCase

  task complete_run;
    if (failures == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(gds_pkg::REG_CTRL, 16'h0000);
    // a zero coordination time has already expired while blocked
    rd(gds_pkg::REG_STAT, 16'h0408);
    rd(3'h7, 16'h0000);
    wr(gds_pkg::REG_KCOMP, 16'hFF03);
    rd(gds_pkg::REG_KCOMP, 16'h0003);
    wr(gds_pkg::REG_STAT, 16'hFFFF);
    rd(gds_pkg::REG_STAT, 16'h0408);
    wr(gds_pkg::REG_COORD, 16'h0002);
    rd(gds_pkg::REG_COORD, 16'h0002);
    // each case starts from blocked, so the timer restarts whenever the case leaves blocked
    foreach (tbl[i])
      runCase(tbl[i]);
    rd(gds_pkg::REG_STAT, 16'h0CC4);
    // voltage minimum above the polarizing voltage of the cases
    wr(gds_pkg::REG_VMIN, 16'h07D0);
    rd(gds_pkg::REG_VMIN, 16'h07D0);
    runCase({16'h0000, 1'h0, 3'h0, 6'h2A, 6'h3F});
    runCase({16'h0012, 1'h0, 3'h4, 6'h2A, 6'h3F});
    wr(gds_pkg::REG_VMIN, 16'h0000);
    // operate leads by 90 degrees: reverse at 60 degrees, on the inclusive edge at 0
    wr(gds_pkg::REG_ANGLE, 16'h003C);
    rd(gds_pkg::REG_ANGLE, 16'h003C);
    runCase({16'h0000, 1'h0, 3'h6, 6'h08, 6'h0C});
    wr(gds_pkg::REG_ANGLE, 16'h0000);
    runCase({16'h0000, 1'h0, 3'h6, 6'h22, 6'h33});
    complete_run();
  end
endmodule : gds_supervisor_bench
